// ==== common/bridge_misc_map.svh ====
// bit positions, reset values and encodings of the bridge misc control register
// assumes inclusion by bare name from design files
`ifndef BRIDGE_MISC_MAP_SVH
`define BRIDGE_MISC_MAP_SVH
`define MODE_HI 15
`define MODE_LO 14
`define CFGBLK_BIT 13
`define FINEIO_BIT 12
`define FREQ_HI 10
`define FREQ_LO 9
`define CFGBLK_RST 1'h1
`define FINEIO_RST 1'h0
`define FREQ_RST 2'h0
`define MODE_RST 2'h0
`define FREQ_33 2'h0
`define MODE_CONV 2'h0
`define MODE_RSVD 2'h2
`define MODE_MAX 2'h1
`define CTRL_WMASK 16'hF600
`define IOW_FINE_MASK 8'h0C
`define IOW_ALL_MASK 8'hFF
`define IOW_RST 8'h00
`endif

// ==== common/bridge_misc_pkg.sv ====
// types for the bridge misc control block
// assumes nothing beyond a SystemVerilog compiler
package bridge_misc_pkg;
	typedef logic [1:0] freq_t;
	typedef logic [1:0] mode_t;
	typedef struct packed {
		logic [1:0] mode;
		logic cfg_block;
		logic fine_io;
		logic [1:0] freq;
		logic [1:0] eff_mode;
		logic [1:0] eff_freq;
		logic [7:0] io_base;
		logic [7:0] io_limit;
	} misc_state_t;
endpackage

// ==== rtl/io_window_match.sv ====
// io window compare: address vs base/limit at 4 KB or 1 KB grain
// assumes base and limit bytes in register format, 16-bit io address
`timescale 1ns/1ps
`default_nettype none
`include "bridge_misc_map.svh"
module io_window_match
(
	input wire logic [15:0] addr,
	input wire logic [7:0] base,
	input wire logic [7:0] limit,
	input wire logic fine,
	output logic hit
);
	logic [5:0] a_k;
	logic [5:0] b_k;
	logic [5:0] l_k;
	// address bits 11:10 take part only in fine mode; coarse mode treats them as full range
	always_comb
	begin
		a_k = addr[15:10];
		b_k = {base[7:4], fine ? base[3:2] : 2'h0};
		l_k = {limit[7:4], fine ? limit[3:2] : 2'h3};
		hit = (a_k >= b_k) && (a_k <= l_k);
	end
endmodule // io_window_match
`default_nettype wire

// ==== rtl/bridge_misc_control.sv ====
// bridge misc control register: config block, fine io window, bus mode/frequency
// assumes config writes/reads arrive as single-cycle strobes on CLOCK
// limitation: mode and frequency reach the bus only at a secondary bus reset strobe
`timescale 1ns/1ps
`default_nettype none
`include "bridge_misc_map.svh"
module bridge_misc_control
	import bridge_misc_pkg::*;
(
	input wire logic CLOCK,
	input wire logic RST_N,
	input wire logic PWR_RST_N,
	input wire logic CTRL_WR,
	input wire logic [15:0] CTRL_WDATA,
	output logic [15:0] CTRL_RDATA,
	input wire logic IOW_WR_BASE,
	input wire logic IOW_WR_LIMIT,
	input wire logic [7:0] IOW_WDATA,
	output logic [7:0] IOW_BASE_RDATA,
	output logic [7:0] IOW_LIMIT_RDATA,
	input wire logic [1:0] SLOT_MAX_FREQ,
	input wire logic [1:0] SLOT_MAX_MODE,
	input wire logic [1:0] SEG_MAX_FREQ,
	input wire logic [1:0] SEG_MAX_MODE,
	input wire logic SEC_BUS_RESET,
	input wire logic [15:0] IO_ADDR,
	output logic IO_HIT,
	input wire logic CFG_REQ,
	input wire logic CFG_FROM_EXPRESS,
	output logic CFG_GRANT,
	output logic CFG_ABORT,
	output logic [1:0] EFF_FREQ,
	output logic [1:0] EFF_MODE,
	output logic OVER_CAP
);
	misc_state_t s_q;
	misc_state_t s_d;
	logic [7:0] wmask;
	logic exceed;
	logic freq_over;
	logic mode_over;
	logic mode_rsvd;
	// capability check on the programmed request; codes rise with speed, so an ordinal compare is enough
	always_comb
	begin
		freq_over = (s_q.freq > SLOT_MAX_FREQ) || (s_q.freq > SEG_MAX_FREQ);
		mode_over = (s_q.mode > SLOT_MAX_MODE) || (s_q.mode > SEG_MAX_MODE);
		mode_rsvd = (s_q.mode >= `MODE_RSVD);
		exceed = freq_over || mode_over || mode_rsvd;
	end
	// next state; the sticky bit only reloads on power reset
	always_comb
	begin
		s_d = s_q;
		wmask = s_q.fine_io ? `IOW_ALL_MASK : ~`IOW_FINE_MASK;
		if (CTRL_WR)
		begin
			s_d.mode = CTRL_WDATA[`MODE_HI:`MODE_LO];
			s_d.cfg_block = CTRL_WDATA[`CFGBLK_BIT];
			s_d.fine_io = CTRL_WDATA[`FINEIO_BIT];
			s_d.freq = CTRL_WDATA[`FREQ_HI:`FREQ_LO];
		end
		// io window bytes; fine bits only land while fine mode is on
		if (IOW_WR_BASE)
			s_d.io_base = (IOW_WDATA & wmask) | (s_q.io_base & ~wmask);
		if (IOW_WR_LIMIT)
			s_d.io_limit = (IOW_WDATA & wmask) | (s_q.io_limit & ~wmask);
		// setting applies at secondary bus reset, as software sequences it
		if (SEC_BUS_RESET)
		begin
			s_d.eff_mode = exceed ? `MODE_CONV : s_q.mode;
			s_d.eff_freq = exceed ? `FREQ_33 : s_q.freq;
		end
		// ordinary reset wins over a same-cycle write; the sticky bit is left alone
		if (!RST_N)
		begin
			s_d.mode = `MODE_RST;
			s_d.fine_io = `FINEIO_RST;
			s_d.freq = `FREQ_RST;
			s_d.eff_mode = `MODE_CONV;
			s_d.eff_freq = `FREQ_33;
			s_d.io_base = `IOW_RST;
			s_d.io_limit = `IOW_RST;
		end
		if (!PWR_RST_N)
			s_d.cfg_block = `CFGBLK_RST;
	end
	// whole state registered at once, so every reset is synchronous
	always_ff @(posedge CLOCK)
	begin
		s_q <= s_d;
	end
	// reads: bit 11 and low bits reserved as zero; fine bits read zero when coarse
	always_comb
	begin
		CTRL_RDATA = {s_q.mode, s_q.cfg_block, s_q.fine_io, 1'h0, s_q.freq, 9'h000};
		IOW_BASE_RDATA = s_q.fine_io ? s_q.io_base : (s_q.io_base & ~`IOW_FINE_MASK);
		IOW_LIMIT_RDATA = s_q.fine_io ? s_q.io_limit : (s_q.io_limit & ~`IOW_FINE_MASK);
	end
	// only express config accesses are gated; smbus/memory pass through
	assign CFG_ABORT = CFG_REQ && CFG_FROM_EXPRESS && s_q.cfg_block;
	assign CFG_GRANT = CFG_REQ && !CFG_ABORT;
	// applied setting straight from flops; the over-capability flag is a live level
	assign EFF_FREQ = s_q.eff_freq;
	assign EFF_MODE = s_q.eff_mode;
	assign OVER_CAP = exceed;
	// window compare sees the stored bytes; hidden fine bits drop out in coarse mode
	io_window_match u_match
	(
		.addr(IO_ADDR),
		.base(s_q.io_base),
		.limit(s_q.io_limit),
		.fine(s_q.fine_io),
		.hit(IO_HIT)
	);
	// checks
	block_abort_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		(CFG_REQ && CFG_FROM_EXPRESS && s_q.cfg_block) |-> CFG_ABORT && !CFG_GRANT)
		else $error("express config not aborted while blocked");
	side_pass_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		(CFG_REQ && !CFG_FROM_EXPRESS) |-> CFG_GRANT)
		else $error("non-express access blocked");
	fine_bits_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		!s_q.fine_io |-> ((IOW_BASE_RDATA & `IOW_FINE_MASK) == 8'h00))
		else $error("fine base bits visible in coarse mode");
	freq_write_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		(CTRL_WR && !$past(CTRL_WR)) |=> CTRL_RDATA[`FREQ_HI:`FREQ_LO] == $past(CTRL_WDATA[`FREQ_HI:`FREQ_LO]))
		else $error("frequency field not stored");
	fallback_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		(SEC_BUS_RESET && exceed) |=> (EFF_FREQ == `FREQ_33) && (EFF_MODE == `MODE_CONV))
		else $error("over-capability request not forced to 33 MHz");
	apply_ok_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		(SEC_BUS_RESET && !exceed && !CTRL_WR) |=> EFF_FREQ == $past(s_q.freq))
		else $error("valid request not applied");
	no_rsvd_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		EFF_MODE <= `MODE_MAX)
		else $error("reserved mode applied");
	sticky_a: assert property (@(posedge CLOCK) disable iff (!PWR_RST_N)
		(!RST_N && !CTRL_WR) |=> s_q.cfg_block == $past(s_q.cfg_block))
		else $error("sticky bit lost on ordinary reset");
	// access gating in the unblocked state, for the side paths and with no request
	cfg_grant_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		(CFG_REQ && !s_q.cfg_block)
		|-> (CFG_GRANT && !CFG_ABORT))
		else $error("config access refused while unblocked");
	abort_src_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		CFG_ABORT
		|-> (CFG_REQ && CFG_FROM_EXPRESS))
		else $error("abort raised for a non-express access");
	idle_quiet_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		!CFG_REQ
		|-> (!CFG_GRANT && !CFG_ABORT))
		else $error("grant or abort without a request");
	// io window bytes: fine bits hidden, kept or stored by mode
	fine_limit_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		!s_q.fine_io
		|-> ((IOW_LIMIT_RDATA & `IOW_FINE_MASK) == 8'h00))
		else $error("fine limit bits visible in coarse mode");
	fine_store_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		(IOW_WR_BASE && s_q.fine_io && !CTRL_WR)
		|=> (IOW_BASE_RDATA == $past(IOW_WDATA)))
		else $error("fine base byte not stored whole");
	lim_store_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		(IOW_WR_LIMIT && s_q.fine_io && !CTRL_WR)
		|=> (IOW_LIMIT_RDATA == $past(IOW_WDATA)))
		else $error("fine limit byte not stored whole");
	coarse_keep_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		(IOW_WR_LIMIT && !s_q.fine_io)
		|=> ((s_q.io_limit & `IOW_FINE_MASK) == ($past(s_q.io_limit) & `IOW_FINE_MASK)))
		else $error("fine limit bits written in coarse mode");
	// control fields land as written; reserved bits stay zero
	fine_rd_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		CTRL_WR
		|=> (CTRL_RDATA[`FINEIO_BIT] == $past(CTRL_WDATA[`FINEIO_BIT])))
		else $error("fine window enable not stored");
	mode_rd_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		CTRL_WR
		|=> (CTRL_RDATA[`MODE_HI:`MODE_LO] == $past(CTRL_WDATA[`MODE_HI:`MODE_LO])))
		else $error("mode field not stored");
	rsvd_zero_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		1'b1
		|-> ((CTRL_RDATA & ~`CTRL_WMASK) == 16'h0000))
		else $error("reserved control bits read nonzero");
	cfg_rd_a: assert property (@(posedge CLOCK) disable iff (!PWR_RST_N)
		CTRL_WR
		|=> (CTRL_RDATA[`CFGBLK_BIT] == $past(CTRL_WDATA[`CFGBLK_BIT])))
		else $error("config block bit not stored");
	// reset values: power reset for the sticky bit, ordinary reset for the rest
	power_rst_a: assert property (@(posedge CLOCK)
		!PWR_RST_N
		|=> (CTRL_RDATA[`CFGBLK_BIT] == `CFGBLK_RST))
		else $error("power reset did not set the block bit");
	rst_vals_a: assert property (@(posedge CLOCK) disable iff (!PWR_RST_N)
		!RST_N
		|=> ((CTRL_RDATA[`FREQ_HI:`FREQ_LO] == `FREQ_RST) && (EFF_MODE == `MODE_CONV)))
		else $error("ordinary reset left frequency or mode set");
	// applied setting moves only at a secondary bus reset or an ordinary reset
	hold_eff_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		!SEC_BUS_RESET
		|=> ($stable(EFF_FREQ) && $stable(EFF_MODE)))
		else $error("applied setting changed without bus reset");
	apply_mode_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		(SEC_BUS_RESET && !exceed)
		|=> (EFF_MODE == $past(s_q.mode)))
		else $error("valid mode not applied");
	// scenario coverage
	abort_cov: cover property (@(posedge CLOCK) CFG_ABORT);
	fallback_cov: cover property (@(posedge CLOCK) SEC_BUS_RESET && exceed);
	fine_hit_cov: cover property (@(posedge CLOCK) s_q.fine_io && IO_HIT);
	apply_cov: cover property (@(posedge CLOCK) SEC_BUS_RESET && !exceed);
	keep_cov: cover property (@(posedge CLOCK) !RST_N && PWR_RST_N && !s_q.cfg_block);
endmodule // bridge_misc_control
`default_nettype wire

// ==== sim/cfg_host_model.sv ====
// host side model: raises configuration requests and marks where they come from
// assumes the bench sets the wanted request off the sampling edge
`timescale 1ns/1ps
`default_nettype none
module cfg_host_model
(
	input wire logic want_req,
	input wire logic want_expr,
	output logic cfg_req,
	output logic cfg_from_express
);
	// source flag only means something while a request stands
	assign cfg_req = want_req;
	assign cfg_from_express = want_req & want_expr;
endmodule // cfg_host_model
`default_nettype wire

// ==== sim/tb_bridge_misc_control.sv ====
// self-checking bench of the bridge misc control register
// assumes the design drives on rising edges; the bench drives on falling ones
`timescale 1ns/1ps
`default_nettype none
module tb_bridge_misc_control;
	logic CLOCK = 0, RST_N = 0, PWR_RST_N = 0, CTRL_WR = 0, IOW_WR_BASE = 0, IOW_WR_LIMIT = 0, SEC_BUS_RESET = 0;
	logic [15:0] CTRL_WDATA = 16'h0, CTRL_RDATA, IO_ADDR = 16'h0;
	logic [7:0] IOW_WDATA = 8'h0, IOW_BASE_RDATA, IOW_LIMIT_RDATA;
	logic [1:0] SLOT_MAX_FREQ = 2'h3, SLOT_MAX_MODE = 2'h1, SEG_MAX_FREQ = 2'h3, SEG_MAX_MODE = 2'h1, EFF_FREQ, EFF_MODE;
	logic IO_HIT, CFG_REQ, CFG_FROM_EXPRESS, CFG_GRANT, CFG_ABORT, OVER_CAP, want_req = 0, want_expr = 0;
	int bad_count = 0, n_checks = 0;
	always #2.5 CLOCK = ~CLOCK;
	cfg_host_model u_cfg_host_model (.want_req(want_req), .want_expr(want_expr), .cfg_req(CFG_REQ),
		.cfg_from_express(CFG_FROM_EXPRESS));
	bridge_misc_control u_bridge_misc_control (.CLOCK(CLOCK), .RST_N(RST_N), .PWR_RST_N(PWR_RST_N),
		.CTRL_WR(CTRL_WR), .CTRL_WDATA(CTRL_WDATA), .CTRL_RDATA(CTRL_RDATA), .IOW_WR_BASE(IOW_WR_BASE),
		.IOW_WR_LIMIT(IOW_WR_LIMIT), .IOW_WDATA(IOW_WDATA), .IOW_BASE_RDATA(IOW_BASE_RDATA),
		.IOW_LIMIT_RDATA(IOW_LIMIT_RDATA), .SLOT_MAX_FREQ(SLOT_MAX_FREQ), .SLOT_MAX_MODE(SLOT_MAX_MODE),
		.SEG_MAX_FREQ(SEG_MAX_FREQ), .SEG_MAX_MODE(SEG_MAX_MODE), .SEC_BUS_RESET(SEC_BUS_RESET),
		.IO_ADDR(IO_ADDR), .IO_HIT(IO_HIT), .CFG_REQ(CFG_REQ), .CFG_FROM_EXPRESS(CFG_FROM_EXPRESS),
		.CFG_GRANT(CFG_GRANT), .CFG_ABORT(CFG_ABORT), .EFF_FREQ(EFF_FREQ), .EFF_MODE(EFF_MODE), .OVER_CAP(OVER_CAP));
	task automatic chk(input logic [15:0] exp, input logic [15:0] got);
	begin
		n_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("wrong value at %0t: expected %h got %h", $time, exp, got);
		end
	end
	endtask
	// one-cycle strobe; value visible at the following falling edge
	task automatic wr(input int sel, input logic [15:0] d);
	begin
		@(negedge CLOCK);
		CTRL_WDATA = d;
		IOW_WDATA = d[7:0];
		CTRL_WR = (sel == 0);
		IOW_WR_BASE = (sel == 1);
		IOW_WR_LIMIT = (sel == 2);
		SEC_BUS_RESET = (sel == 3);
		@(negedge CLOCK);
		{CTRL_WR, IOW_WR_BASE, IOW_WR_LIMIT, SEC_BUS_RESET} = 4'h0;
	end
	endtask
	task automatic report_and_stop;
	begin
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	end
	endtask
	// main sequence; ordinary and power reset held four cycles together
	initial
	begin
		repeat (4) @(negedge CLOCK);
		{RST_N, PWR_RST_N} = 2'h3;
		chk(16'h2000, CTRL_RDATA);
		{want_req, want_expr} = 2'h3;
		#1 chk(16'h0001, {CFG_GRANT, CFG_ABORT});
		want_expr = 0;
		#1 chk(16'h0002, {CFG_GRANT, CFG_ABORT});
		wr(0, 16'h5FFF);
		chk(16'h5600, CTRL_RDATA);
		want_expr = 1;
		#1 chk(16'h0002, {CFG_GRANT, CFG_ABORT});
		// ordinary reset must not touch the sticky block bit
		RST_N = 0;
		@(negedge CLOCK) RST_N = 1;
		chk(16'h0000, CTRL_RDATA);
		want_req = 0;
		wr(1, 16'h00FC);
		chk(16'h00F0, IOW_BASE_RDATA);
		wr(2, 16'h00F0);
		IO_ADDR = 16'hFC00;
		#1 chk(16'h0001, IO_HIT);
		wr(0, 16'h1000);
		wr(1, 16'h0014);
		wr(2, 16'h0014);
		chk(16'h1414, {IOW_BASE_RDATA, IOW_LIMIT_RDATA});
		IO_ADDR = 16'h1400;
		#1 chk(16'h0001, IO_HIT);
		IO_ADDR = 16'h1800;
		#1 chk(16'h0000, IO_HIT);
		// every frequency in PCI-X mode 1, then set by a secondary bus reset
		// hot plug is off in this bench, so mode and frequency are written directly
		for (int f = 0; f < 4; f++)
		begin
			wr(0, {5'h08, f[1:0], 9'h0});
			wr(3, 16'h0);
			chk({12'h0, 2'h1, f[1:0]}, {12'h0, EFF_MODE, EFF_FREQ});
		end
		SLOT_MAX_FREQ = 2'h1;
		#1 chk(16'h0001, OVER_CAP);
		wr(3, 16'h0);
		chk(16'h0000, {EFF_MODE, EFF_FREQ});
		{SLOT_MAX_FREQ, SEG_MAX_MODE} = 4'hD;
		wr(0, 16'h4400);
		wr(3, 16'h0);
		chk(16'h0006, {OVER_CAP, EFF_MODE, EFF_FREQ});
		SEG_MAX_MODE = 2'h0;
		wr(3, 16'h0);
		chk(16'h0010, {OVER_CAP, EFF_MODE, EFF_FREQ});
		report_and_stop();
	end
endmodule // tb_bridge_misc_control
`default_nettype wire
